// *** common/bpm_map.vh ***
// Constants for the battery pack mode controller: timing figures and encodings.
// Assumes a 250 MHz sys_clk; counts derive from times in their own units.
// Notes on behaviour
// [R1] Valid input means charge; otherwise hold-off low is boost, high is high-impedance.
// [R2] Boost to charge or back passes two seconds of all switches off.
// [R3] Base variant: boost enables after button held low over 100 ms; a charge-to-boost swap enters boost after its wait without a press.
// [R4] Flashlight variant: boost enables after button held low over 30 ms; a charge-to-boost swap enters boost after its wait without a press.
// [R5] Flashlight variant: press over 3 s while light off turns it on.
// [R6] Press held 3 s while light on turns the flashlight off.
// [R7] Flashlight locked out by supply flag with 3.3 V / 2.9 V hysteresis.
// [R8] Output undervoltage turns input path off, retry after two seconds.
// [R9] Charge mode: input path on, converter switches run as step-down charger.
// [R10] Boost mode: converter steps up to 5 V, input path off, reverse blocked.
// [R11] High-impedance mode holds all three power switches off.
// [R12] Charge cycle starts in precondition, moves on at precondition threshold.
// [R13] Precondition current target is 10 percent of fast charge current.
// [R14] Fast charge is constant current until termination, then constant-voltage top-off.
// [R15] Top-off ends at current below 15 percent, entering end of charge.
// [R16] End of charge stops charging but keeps watching battery voltage.
// [R17] Battery 200 mV below termination restarts charging in constant current.
// [R18] Flags and button synchronised; intervals counted in clock cycles as parameters.
// [R19] Early release restarts a button timer; one hold fires one action.
`ifndef BPM_MAP_VH
`define BPM_MAP_VH
`define BPM_CLK_MHZ 250
`define BPM_TRAN_MS 2000
`define BPM_HICCUP_MS 2000
`define BPM_PB_BASE_MS 100
`define BPM_PB_FL_MS 30
`define BPM_FL_MS 3000
`define BPM_MS_CYC(ms) ((ms) * 1000 * `BPM_CLK_MHZ)
`define BPM_MODE_HZ 2'h0
`define BPM_MODE_CHG 2'h1
`define BPM_MODE_BST 2'h2
`define BPM_CHG_PRE 3'h0
`define BPM_CHG_FAST 3'h1
`define BPM_CHG_TOP 3'h2
`define BPM_CHG_EOC 3'h3
`define BPM_CHG_IDLE 3'h4
`define BPM_ITGT_OFF 2'h0
`define BPM_ITGT_10PCT 2'h1
`define BPM_ITGT_FULL 2'h2
`define BPM_ITGT_CV 2'h3
`endif

// *** logic/bpm_mode_ctrl.v ***
// Mode, push-button, hiccup and charge-state control of a single-cell battery pack manager.
// Assumes comparator flags arrive as levels from the analog stage; all are resynchronised here.
`timescale 1ns/10ps
`include "bpm_map.vh"

module bpm_sync (
  input wire clk,
  input wire rst_n,
  input wire d,
  output reg q
);
  reg meta_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // bpm_sync

module bpm_mode_ctrl #(
  parameter FLASH_VARIANT = 0,
  parameter [31:0] TRAN_CYC = `BPM_MS_CYC(`BPM_TRAN_MS),
  parameter [31:0] HICCUP_CYC = `BPM_MS_CYC(`BPM_HICCUP_MS),
  parameter [31:0] PB_BASE_CYC = `BPM_MS_CYC(`BPM_PB_BASE_MS),
  parameter [31:0] PB_FL_CYC = `BPM_MS_CYC(`BPM_PB_FL_MS),
  parameter [31:0] FL_CYC = `BPM_MS_CYC(`BPM_FL_MS)
) (
  input wire sys_clk,
  input wire rst_n,
  input wire hold_off_pin,
  input wire push_button_input_n,
  input wire input_valid,
  input wire bat_above_precond,
  input wire bat_at_term,
  input wire bat_below_recharge,
  input wire chg_below_eoc,
  input wire out_undervoltage,
  input wire supply_above_rise,
  input wire supply_above_fall,
  output reg input_path_switch_en_r,
  output reg converter_en_r,
  output reg converter_step_up_r,
  output reg reverse_block_r,
  output reg flashlight_drive_r,
  output reg [1:0] mode_r,
  output reg [2:0] charge_state_r,
  output reg [1:0] charge_current_set_r,
  output reg low_supply_lockout_r
);
  wire hz_s, pb_n_s, vin_s, pre_s, term_s, rech_s, eoc_s, uv_s, rise_s, fall_s;

  // Every asynchronous flag and the button pass through two flops
  bpm_sync u_s0 (.clk(sys_clk), .rst_n(rst_n), .d(hold_off_pin), .q(hz_s)); // R18
  bpm_sync u_s1 (.clk(sys_clk), .rst_n(rst_n), .d(push_button_input_n), .q(pb_n_s));
  bpm_sync u_s2 (.clk(sys_clk), .rst_n(rst_n), .d(input_valid), .q(vin_s));
  bpm_sync u_s3 (.clk(sys_clk), .rst_n(rst_n), .d(bat_above_precond), .q(pre_s));
  bpm_sync u_s4 (.clk(sys_clk), .rst_n(rst_n), .d(bat_at_term), .q(term_s));
  bpm_sync u_s5 (.clk(sys_clk), .rst_n(rst_n), .d(bat_below_recharge), .q(rech_s));
  bpm_sync u_s6 (.clk(sys_clk), .rst_n(rst_n), .d(chg_below_eoc), .q(eoc_s));
  bpm_sync u_s7 (.clk(sys_clk), .rst_n(rst_n), .d(out_undervoltage), .q(uv_s));
  bpm_sync u_s8 (.clk(sys_clk), .rst_n(rst_n), .d(supply_above_rise), .q(rise_s));
  bpm_sync u_s9 (.clk(sys_clk), .rst_n(rst_n), .d(supply_above_fall), .q(fall_s));

  localparam [31:0] PB_ON_CYC = (FLASH_VARIANT != 0) ? PB_FL_CYC : PB_BASE_CYC;

  // Mode request from hold-off pin and input validity
  wire [1:0] want_mode = vin_s ? `BPM_MODE_CHG : (hz_s ? `BPM_MODE_HZ : `BPM_MODE_BST); // R1

  reg [31:0] tran_cnt_r;
  reg tran_busy_r;
  reg [1:0] last_active_r;
  reg boost_armed_r;
  reg [31:0] pb_cnt_r;
  reg pb_fired_on_r;
  reg pb_fired_fl_r;
  reg hiccup_r;
  reg [31:0] hic_cnt_r;

  wire pb_low = ~pb_n_s;
  wire boost_ok = boost_armed_r;

  // Push-button timer; restarts when released, each hold acts once
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_cnt_r <= 32'h0;
      pb_fired_on_r <= 1'b0;
      pb_fired_fl_r <= 1'b0;
    end else if (!pb_low) begin
      pb_cnt_r <= 32'h0; // R19
      pb_fired_on_r <= 1'b0;
      pb_fired_fl_r <= 1'b0;
    end else begin
      if (pb_cnt_r != 32'hffffffff)
        pb_cnt_r <= pb_cnt_r + 32'h1;
      if (pb_cnt_r > PB_ON_CYC)
        pb_fired_on_r <= 1'b1;
      if (pb_cnt_r > FL_CYC)
        pb_fired_fl_r <= 1'b1; // R19
    end
  end

  wire pb_on_evt = pb_low && !pb_fired_on_r && (pb_cnt_r > PB_ON_CYC); // R3 R4
  wire pb_fl_evt = pb_low && !pb_fired_fl_r && (pb_cnt_r > FL_CYC);

  // Boost arms on a qualifying press while hold-off is low; drops when boost is not wanted
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boost_armed_r <= 1'b0;
    end else if (hz_s || vin_s) begin
      boost_armed_r <= 1'b0;
    end else if (pb_on_evt) begin
      boost_armed_r <= 1'b1; // R3 R4
    end
  end

  // Supply lockout with hysteresis: clears above rise point, sets below fall point
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_supply_lockout_r <= 1'b1;
    end else if (!fall_s) begin
      low_supply_lockout_r <= 1'b1; // R7
    end else if (rise_s) begin
      low_supply_lockout_r <= 1'b0; // R7
    end
  end

  // Flashlight toggles on a 3 s hold, never while locked out
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flashlight_drive_r <= 1'b0;
    end else if (FLASH_VARIANT == 0 || low_supply_lockout_r) begin
      flashlight_drive_r <= 1'b0; // R7
    end else if (pb_fl_evt) begin
      flashlight_drive_r <= ~flashlight_drive_r; // R5 R6
    end
  end

  // Mode sequencer: a direct boost-charge swap takes the high-impedance wait; a high-impedance request in between cancels it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `BPM_MODE_HZ;
      last_active_r <= `BPM_MODE_HZ;
      tran_busy_r <= 1'b0;
      tran_cnt_r <= 32'h0;
    end else if (tran_busy_r) begin
      mode_r <= `BPM_MODE_HZ; // R2
      if (want_mode == last_active_r || want_mode == `BPM_MODE_HZ) begin
        tran_busy_r <= 1'b0;
        tran_cnt_r <= 32'h0;
        last_active_r <= `BPM_MODE_HZ;
      end else if (tran_cnt_r >= TRAN_CYC - 32'h1) begin
        tran_busy_r <= 1'b0; // R2
        tran_cnt_r <= 32'h0;
        mode_r <= want_mode;
        last_active_r <= want_mode;
      end else begin
        tran_cnt_r <= tran_cnt_r + 32'h1;
      end
    end else begin
      case (want_mode)
        `BPM_MODE_CHG: begin
          if (last_active_r == `BPM_MODE_BST) begin
            tran_busy_r <= 1'b1; // R2
            mode_r <= `BPM_MODE_HZ;
          end else begin
            mode_r <= `BPM_MODE_CHG;
            last_active_r <= `BPM_MODE_CHG;
          end
        end
        `BPM_MODE_BST: begin
          if (last_active_r == `BPM_MODE_CHG) begin
            tran_busy_r <= 1'b1; // R2
            mode_r <= `BPM_MODE_HZ;
          end else if (boost_ok) begin
            mode_r <= `BPM_MODE_BST;
            last_active_r <= `BPM_MODE_BST;
          end else begin
            mode_r <= `BPM_MODE_HZ;
          end
        end
        default: begin
          mode_r <= `BPM_MODE_HZ;
          last_active_r <= `BPM_MODE_HZ;
        end
      endcase
    end
  end

  // Hiccup: undervoltage in charge mode cuts input path for the retry time
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hiccup_r <= 1'b0;
      hic_cnt_r <= 32'h0;
    end else if (hiccup_r) begin
      if (hic_cnt_r >= HICCUP_CYC - 32'h1) begin
        hiccup_r <= 1'b0; // R8
        hic_cnt_r <= 32'h0;
      end else begin
        hic_cnt_r <= hic_cnt_r + 32'h1;
      end
    end else if (uv_s && mode_r == `BPM_MODE_CHG) begin
      hiccup_r <= 1'b1; // R8
      hic_cnt_r <= 32'h0;
    end
  end

  // Charge state machine, reset to precondition on each new charge entry
  reg [2:0] chg_nxt;
  always @* begin
    chg_nxt = charge_state_r;
    case (charge_state_r)
      `BPM_CHG_IDLE: chg_nxt = `BPM_CHG_PRE; // R12
      `BPM_CHG_PRE: if (pre_s) chg_nxt = `BPM_CHG_FAST; // R12
      `BPM_CHG_FAST: if (term_s) chg_nxt = `BPM_CHG_TOP; // R14
      `BPM_CHG_TOP: if (eoc_s) chg_nxt = `BPM_CHG_EOC; // R15
      `BPM_CHG_EOC: if (rech_s) chg_nxt = `BPM_CHG_FAST; // R16 R17
      default: chg_nxt = `BPM_CHG_IDLE;
    endcase
    if (mode_r != `BPM_MODE_CHG)
      chg_nxt = `BPM_CHG_IDLE;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_state_r <= `BPM_CHG_IDLE;
      charge_current_set_r <= `BPM_ITGT_OFF;
    end else begin
      charge_state_r <= chg_nxt;
      case (chg_nxt)
        `BPM_CHG_PRE: charge_current_set_r <= `BPM_ITGT_10PCT; // R13
        `BPM_CHG_FAST: charge_current_set_r <= `BPM_ITGT_FULL; // R14
        `BPM_CHG_TOP: charge_current_set_r <= `BPM_ITGT_CV; // R14
        default: charge_current_set_r <= `BPM_ITGT_OFF; // R16
      endcase
    end
  end

  // Switch drive per mode
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_path_switch_en_r <= 1'b0;
      converter_en_r <= 1'b0;
      converter_step_up_r <= 1'b0;
      reverse_block_r <= 1'b0;
    end else begin
      case (mode_r)
        `BPM_MODE_CHG: begin
          input_path_switch_en_r <= !hiccup_r && !(uv_s); // R9 R8
          converter_en_r <= (chg_nxt != `BPM_CHG_EOC) && (chg_nxt != `BPM_CHG_IDLE); // R9 R16
          converter_step_up_r <= 1'b0;
          reverse_block_r <= 1'b0;
        end
        `BPM_MODE_BST: begin
          input_path_switch_en_r <= 1'b0; // R10
          converter_en_r <= 1'b1;
          converter_step_up_r <= 1'b1;
          reverse_block_r <= 1'b1;
        end
        default: begin
          input_path_switch_en_r <= 1'b0; // R11
          converter_en_r <= 1'b0;
          converter_step_up_r <= 1'b0;
          reverse_block_r <= 1'b0;
        end
      endcase
    end
  end
endmodule // bpm_mode_ctrl

// *** verif/bpm_power_stage.sv ***
// Comparator model of the analog stage, driven by bench-set millivolt and percent levels.
// Assumes the bench changes levels shortly after a clock edge.
`timescale 1ns/10ps
module bpm_power_stage #(
  parameter int VIN_OK_MV = 4500,
  parameter int PRE_MV = 3000,
  parameter int TERM_MV = 4200,
  parameter int UV_MV = 4250
) (
  input int vin_mv,
  input int vbat_mv,
  input int vout_mv,
  input int ichg_pct,
  output wire input_valid,
  output wire bat_above_precond,
  output wire bat_at_term,
  output wire bat_below_recharge,
  output wire chg_below_eoc,
  output wire out_undervoltage,
  output wire supply_above_rise,
  output wire supply_above_fall
);
  assign input_valid = vin_mv > VIN_OK_MV;
  assign bat_above_precond = vbat_mv > PRE_MV;
  assign bat_at_term = vbat_mv >= TERM_MV;
  assign bat_below_recharge = vbat_mv <= TERM_MV - 200;
  assign chg_below_eoc = ichg_pct < 15;
  assign out_undervoltage = vout_mv <= UV_MV;
  assign supply_above_rise = vbat_mv > 3300;
  assign supply_above_fall = vbat_mv > 2900;
endmodule // bpm_power_stage

// *** verif/bpm_mode_monitor.sv ***
// Port checker for the mode controller.
// Assumes the 2-flop input sync and one-cycle output latencies of the controller.
`timescale 1ns/10ps
module bpm_mode_monitor #(
  parameter [31:0] TRAN_CYC = 20,
  parameter [31:0] PB_FL_CYC = 3,
  parameter [31:0] FL_CYC = 10
) (
  input wire sys_clk,
  input wire rst_n,
  input wire hold_off_pin,
  input wire push_button_input_n,
  input wire input_valid,
  input wire out_undervoltage,
  input wire supply_above_fall,
  input wire input_path_switch_en_r,
  input wire converter_en_r,
  input wire converter_step_up_r,
  input wire reverse_block_r,
  input wire flashlight_drive_r,
  input wire [1:0] mode_r,
  input wire [2:0] charge_state_r,
  input wire [1:0] charge_current_set_r,
  input wire low_supply_lockout_r
);
  reg [31:0] hz_cnt_r;
  reg [31:0] pb_cnt_r;
  reg [1:0] last_r;
  reg pb_seen_r;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hz_cnt_r <= 0;
      pb_cnt_r <= 0;
      last_r <= 2'h0;
      pb_seen_r <= 1'b0;
    end else begin
      hz_cnt_r <= (mode_r == 2'h0) ? hz_cnt_r + 1 : 0;
      pb_cnt_r <= push_button_input_n ? 0 : pb_cnt_r + 1;
      // Raw count runs ahead of the synced one, so this is a safe lower bound
      pb_seen_r <= pb_seen_r | (pb_cnt_r > PB_FL_CYC);
      if (mode_r != 2'h0)
        last_r <= mode_r;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_VALID_NO_BOOST: assert property (input_valid[*4] |-> mode_r != 2'h2) else $error("boost with valid input");
  AST_HOLD_OFF_HZ: assert property ((hold_off_pin && !input_valid)[*4] |-> mode_r == 2'h0) else $error("no hz");
  AST_TRAN_DWELL: assert property (mode_r != 2'h0 && $past(mode_r) == 2'h0 && last_r != 2'h0 && last_r != mode_r
    |-> hz_cnt_r >= TRAN_CYC) else $error("short transition wait");
  AST_BOOST_PRESS: assert property ($rose(mode_r == 2'h2) |-> pb_seen_r) else $error("boost without press");
  AST_FLASH_TOGGLE: assert property ($changed(flashlight_drive_r) && !low_supply_lockout_r
    |-> pb_cnt_r > FL_CYC) else $error("flashlight toggled early");
  AST_LOCKOUT_SET: assert property ((!supply_above_fall)[*4] |-> low_supply_lockout_r) else $error("no lockout");
  AST_LOCKOUT_DARK: assert property (low_supply_lockout_r[*2] |-> !flashlight_drive_r) else $error("light on");
  AST_UV_PATH_OFF: assert property (out_undervoltage[*4] |-> !input_path_switch_en_r) else $error("path on");
  AST_BOOST_SW: assert property (mode_r == 2'h2 |=> converter_en_r && converter_step_up_r && reverse_block_r
    && !input_path_switch_en_r) else $error("boost switches wrong");
  AST_HZ_SW: assert property (mode_r == 2'h0 |=> !input_path_switch_en_r && !converter_en_r) else $error("hz on");
  AST_PRE_CURRENT: assert property ((mode_r == 2'h1 && charge_state_r == 3'h0)[*2]
    |-> charge_current_set_r == 2'h1) else $error("precondition current wrong");
  AST_EOC_STOP: assert property (charge_state_r == 3'h3 [*2] |-> !converter_en_r && charge_current_set_r == 2'h0)
    else $error("charging in end of charge");
  COV_BOOST: cover property ($rose(mode_r == 2'h2));
  COV_LIGHT: cover property ($rose(flashlight_drive_r));
  COV_EOC: cover property ($rose(charge_state_r == 3'h3));
endmodule // bpm_mode_monitor
bind bpm_mode_ctrl bpm_mode_monitor #(.TRAN_CYC(TRAN_CYC), .PB_FL_CYC(PB_FL_CYC), .FL_CYC(FL_CYC)) i_bpm_mode_monitor (.*);

// *** verif/battery_pack_mode_controller_bench.sv ***
// Self-checking bench: flashlight variant with shortened counts, analog stage as comparator model.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module battery_pack_mode_controller_bench;
  reg sys_clk = 0;
  reg rst_n = 0;
  reg hold_off_pin = 0;
  reg pb_n = 1;
  int vbat = 3700, input_supply = 0, vout = 5000, ichg = 100;
  int n_errors = 0, n_tests = 0, cyc = 0;
  wire iv, pre, term, rchg, eoc, uv, rise, fall, path, cen, up, rb, fl, lock;
  wire [1:0] mode, iset;
  wire [2:0] cst;
  logic [2:0] exp_mode[$], exp_cst[$];
  logic [1:0] prev_mode = 2'h0;
  logic [2:0] prev_cst = 3'h4;
  always #2 sys_clk = ~sys_clk;
  bpm_power_stage i_bpm_power_stage (.vin_mv(input_supply), .vbat_mv(vbat), .vout_mv(vout), .ichg_pct(ichg),
    .input_valid(iv), .bat_above_precond(pre), .bat_at_term(term), .bat_below_recharge(rchg),
    .chg_below_eoc(eoc), .out_undervoltage(uv), .supply_above_rise(rise), .supply_above_fall(fall));
  bpm_mode_ctrl #(.FLASH_VARIANT(1), .TRAN_CYC(20), .HICCUP_CYC(20), .PB_BASE_CYC(5), .PB_FL_CYC(3), .FL_CYC(10))
    i_bpm_mode_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .hold_off_pin(hold_off_pin), .push_button_input_n(pb_n),
    .input_valid(iv), .bat_above_precond(pre), .bat_at_term(term), .bat_below_recharge(rchg),
    .chg_below_eoc(eoc), .out_undervoltage(uv), .supply_above_rise(rise), .supply_above_fall(fall),
    .input_path_switch_en_r(path), .converter_en_r(cen), .converter_step_up_r(up), .reverse_block_r(rb),
    .flashlight_drive_r(fl), .mode_r(mode), .charge_state_r(cst), .charge_current_set_r(iset),
    .low_supply_lockout_r(lock));
  task automatic compare(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic press(input int n);
    pb_n = 0;
    tick(n);
    pb_n = 1;
    tick(1);
  endtask
  task print_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Each change of mode or charge state consumes the oldest expectation
  always @(negedge sys_clk) begin
    if (rst_n && mode !== prev_mode) begin
      compare({1'b0, mode}, exp_mode.size() ? exp_mode.pop_front() : 3'h7);
      prev_mode = mode;
    end
    if (rst_n && cst !== prev_cst) begin
      compare(cst, exp_cst.size() ? exp_cst.pop_front() : 3'h7);
      prev_cst = cst;
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(29));
    tick(2);
    rst_n = 1;
    compare(lock, 1);
    tick(4);
    press($urandom_range(1, 3));
    tick(8);
    compare(mode, 0);
    exp_mode.push_back(2);
    press(14);
    tick(3);
    compare(fl, 1);
    press(30);
    tick(3);
    compare(fl, 0);
    vbat = 2000 + $urandom_range(0, 899);
    tick(6);
    compare(lock, 1);
    vbat = 2901 + $urandom_range(0, 398);
    tick(6);
    compare(lock, 1);
    exp_mode.push_back(0);
    exp_mode.push_back(1);
    exp_cst.push_back(0);
    vbat = 2000 + $urandom_range(0, 999);
    input_supply = 4501 + $urandom_range(0, 999);
    for (int i = 0; i < 100 && mode !== 2'h1; i++)
      tick(1);
    tick(3);
    compare(iset, 1);
    compare({path, up}, 2);
    exp_cst.push_back(1);
    vbat = 3001 + $urandom_range(0, 1198);
    tick(6);
    compare(iset, 2);
    exp_cst.push_back(2);
    vbat = 4200 + $urandom_range(0, 200);
    tick(6);
    compare(iset, 3);
    exp_cst.push_back(3);
    ichg = $urandom_range(0, 14);
    tick(6);
    compare(cen, 0);
    exp_cst.push_back(1);
    ichg = 15 + $urandom_range(0, 85);
    vbat = 3001 + $urandom_range(0, 999);
    tick(6);
    vout = 3000 + $urandom_range(0, 1250);
    tick(4);
    vout = 4251 + $urandom_range(0, 999);
    tick(6);
    compare(path, 0);
    tick(8);
    compare(path, 0);
    tick(20);
    compare(path, 1);
    exp_mode.push_back(0);
    exp_cst.push_back(4);
    input_supply = 0;
    tick(8);
    hold_off_pin = 1;
    tick(8);
    compare(mode, 0);
    compare(3'(exp_mode.size() + exp_cst.size()), 0);
    print_verdict;
  end
endmodule // battery_pack_mode_controller_bench
